// ===== shared/aic_pkg.sv
// package: constants for the converter input select and conversion control block
package aic_pkg;
  localparam logic [3:0] SRC_EXT0     = 4'h0;
  localparam logic [3:0] SRC_AVDD     = 4'h1;
  localparam logic [3:0] SRC_AVDD_2   = 4'h2;
  localparam logic [3:0] SRC_AVDD_4   = 4'h3;
  localparam logic [3:0] SRC_EXT1     = 4'h4;
  localparam logic [3:0] SRC_VVR      = 4'h5;
  localparam logic [3:0] SRC_VVR_2    = 4'h6;
  localparam logic [3:0] SRC_VVR_4    = 4'h7;
  localparam logic [3:0] CH_LAST      = 4'hb;
  localparam int         NUM_CH       = 12;
  localparam int         SAMPLE_TICKS = 4;
  localparam int         CONV_TICKS   = 12;
  localparam int         TOTAL_TICKS  = SAMPLE_TICKS + CONV_TICKS;
  localparam int         RES_W        = 12;
  // analog mux code driven to the core
  localparam logic [2:0] AMUX_FLOAT   = 3'h0;
  localparam logic [2:0] AMUX_EXT     = 3'h1;
  localparam logic [2:0] AMUX_AVDD    = 3'h2;
  localparam logic [2:0] AMUX_VVR     = 3'h3;
  localparam logic [2:0] AMUX_GND     = 3'h4;
  localparam logic [1:0] ATT_1        = 2'h0;
  localparam logic [1:0] ATT_2        = 2'h1;
  localparam logic [1:0] ATT_4        = 2'h2;
  localparam logic [11:0] RES_RESET   = 12'h000;
  localparam logic [7:0] DIV_RESET    = 8'h00;
endpackage

// ===== rtl/aic_clk_div.sv
// conversion clock tick generator: one tick every 2**sel system clocks
module aic_clk_div (
  input  wire logic       clock_i,  // system clock
  input  wire logic       srst_i,   // sync reset
  input  wire logic       ce_i,     // clock enable
  input  wire logic       run_i,    // counting allowed
  input  wire logic [2:0] sel_i,    // divide code
  output logic            tick_o    // one conversion clock period elapsed
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire  [7:0] limit = 8'((9'h001 << sel_i) - 9'h001);
  wire        wrap  = (cnt_r >= limit);
  assign tick_o  = run_i && wrap;
  assign cnt_nxt = (!run_i || wrap) ? aic_pkg::DIV_RESET : 8'(cnt_r + 8'h01);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_r <= aic_pkg::DIV_RESET;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== rtl/aic_top.sv
// converter input routing, start and busy control, result placement
// Function
// - analog-assigned pin disables all other pin functions
// - analog-assigned pin disconnects its software pull-high
// - analog-assigned pin overrides port direction control
// - source codes 0000, 0100, 1100-1111 convert the selected external channel
// - source codes 0001-0011 and 0101-0111 use internal signal, all external channels off
// - channel codes 0000-1011 route a channel, others leave input floating
// - codes 0001-0011 pick supply, half, quarter
// - codes 0101-0111 pick amplifier output, half, quarter
// - codes 10xx connect converter input to ground
// - low-high-low start pulse begins one conversion on its falling edge
// - busy set when conversion starts, cleared at completion
// - completion sets request flag; interrupt raised only when enabled
// - conversion clock is system clock, undivided or divided
// - converter runs only while power enable is high; software waits start-up
// - conversion lasts 16 clock periods: 4 sampling, 12 converting
// - divide codes 000-111 select divide by 1 to 128
// - format bit splits result 8/4 or 4/8 across high and low
module aic_top (
  input  wire logic        clock_i,           // 40 MHz system clock
  input  wire logic        srst_i,            // sync reset, active high
  input  wire logic        ce_i,              // clock enable
  input  wire logic [3:0]  input_source_select_i,     // source code
  input  wire logic [3:0]  external_channel_select_i, // channel code
  input  wire logic [2:0]  conv_clock_divide_i,       // divide code
  input  wire logic        conv_power_enable_i,       // converter power
  input  wire logic        result_format_select_i,    // result layout
  input  wire logic        start_i,           // software start bit
  input  wire logic        int_enable_i,      // converter interrupt enable
  input  wire logic        req_clear_i,       // software clears request flag
  input  wire logic [11:0] pin_analog_sel_i,  // per pin: assigned as analog input
  input  wire logic [11:0] pin_pullup_i,      // software pull-high settings
  input  wire logic [11:0] pin_dir_in_i,      // port control: 1 means input
  input  wire logic [11:0] pin_func_en_i,     // other functions requested
  input  wire logic        core_bit_i,        // comparator decision from core
  output logic [11:0]      pin_pullup_o,      // effective pull-high enables
  output logic [11:0]      pin_dir_in_o,      // effective input direction
  output logic [11:0]      pin_func_en_o,     // effective other-function enables
  output logic [11:0]      ch_connect_o,      // one-hot external channel switch
  output logic [2:0]       amux_sel_o,        // analog mux source
  output logic [1:0]       atten_o,           // internal signal attenuation
  output logic             core_power_o,      // core powered
  output logic             core_sample_o,     // core sampling phase
  output logic             conv_busy_flag_o,  // busy flag
  output logic             int_req_flag_o,    // converter interrupt request flag
  output logic             irq_o,             // interrupt to controller
  output logic [7:0]       result_high_reg_o, // result high register
  output logic [7:0]       result_low_reg_o   // result low register
);
  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} aic_state_t;

  function automatic logic is_internal(input logic [3:0] s);
    return (s[3:2] == 2'b00 && s[1:0] != 2'b00) || (s[3:2] == 2'b01 && s[1:0] != 2'b00);
  endfunction

  function automatic logic is_ground(input logic [3:0] s);
    return s[3:2] == 2'b10;
  endfunction

  aic_state_t  state_r, state_nxt;
  logic [3:0]  tick_cnt_r, tick_cnt_nxt;
  logic [11:0] sar_r, sar_nxt;
  logic        busy_r, req_r, start_q_r;
  logic [7:0]  hi_r, lo_r;

  // pin overrides
  assign pin_func_en_o = pin_func_en_i & ~pin_analog_sel_i;
  assign pin_pullup_o  = pin_pullup_i & ~pin_analog_sel_i;
  assign pin_dir_in_o  = pin_dir_in_i | pin_analog_sel_i;

  // source routing
  wire        src_int   = is_internal(input_source_select_i);
  wire        src_gnd   = is_ground(input_source_select_i);
  wire        src_ext   = !src_int && !src_gnd;
  wire        ch_valid  = external_channel_select_i <= aic_pkg::CH_LAST;
  wire [11:0] ch_onehot = 12'h001 << external_channel_select_i;
  assign ch_connect_o = (src_ext && ch_valid) ? ch_onehot : 12'h000;
  assign amux_sel_o = src_gnd ? aic_pkg::AMUX_GND :
                      src_int ? (input_source_select_i[2] ? aic_pkg::AMUX_VVR
                                                          : aic_pkg::AMUX_AVDD)
                      : (ch_valid ? aic_pkg::AMUX_EXT : aic_pkg::AMUX_FLOAT);
  // low two bits 01/10/11 give full, half, quarter
  assign atten_o = !src_int ? aic_pkg::ATT_1 :
                   (input_source_select_i[1:0] == 2'b10) ? aic_pkg::ATT_2 :
                   (input_source_select_i[1:0] == 2'b11) ? aic_pkg::ATT_4 : aic_pkg::ATT_1;

  // conversion clock tick; counter held while idle so sampling starts aligned
  logic tick;
  aic_clk_div u_div (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .run_i   (busy_r),
    .sel_i   (conv_clock_divide_i),
    .tick_o  (tick)
  );

  // falling edge of start completes the low-high-low pulse
  wire start_fall = start_q_r && !start_i;
  wire go         = start_fall && conv_power_enable_i;
  wire last_tick  = tick && (tick_cnt_r == 4'(aic_pkg::TOTAL_TICKS - 1));
  // a completion that meets power loss counts as an abort: no request, no load
  wire done       = (state_r == CONVERT) && last_tick && conv_power_enable_i;

  always_comb begin
    state_nxt    = state_r;
    tick_cnt_nxt = tick_cnt_r;
    sar_nxt      = sar_r;
    case (state_r)
      IDLE: begin
        tick_cnt_nxt = 4'h0;
        if (go) begin
          state_nxt = SAMPLE;
          sar_nxt   = aic_pkg::RES_RESET;
        end
      end
      SAMPLE: begin
        if (tick) begin
          tick_cnt_nxt = 4'(tick_cnt_r + 4'h1);
          if (tick_cnt_r == 4'(aic_pkg::SAMPLE_TICKS - 1)) begin
            state_nxt = CONVERT;
          end
        end
      end
      CONVERT: begin
        if (tick) begin
          tick_cnt_nxt = 4'(tick_cnt_r + 4'h1);
          sar_nxt      = {sar_r[10:0], core_bit_i};  // msb first
          if (last_tick) begin
            state_nxt = IDLE;
          end
        end
      end
      default: state_nxt = IDLE;
    endcase
    // power loss aborts
    if (!conv_power_enable_i) begin
      state_nxt = IDLE;
    end
  end

  wire [11:0] res_bits = {sar_r[10:0], core_bit_i};
  // format 0: high=D[11:4], low={D[3:0],0000}; format 1: high={0000,D[11:8]}, low=D[7:0]
  wire [7:0] hi_nxt = result_format_select_i ? {4'h0, res_bits[11:8]} : res_bits[11:4];
  wire [7:0] lo_nxt = result_format_select_i ? res_bits[7:0] : {res_bits[3:0], 4'h0};

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r    <= IDLE;
      tick_cnt_r <= 4'h0;
      sar_r      <= aic_pkg::RES_RESET;
      busy_r     <= 1'b0;
      req_r      <= 1'b0;
      start_q_r  <= 1'b0;
      hi_r       <= 8'h00;
      lo_r       <= 8'h00;
    end else if (ce_i) begin
      state_r    <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      sar_r      <= sar_nxt;
      start_q_r  <= start_i;
      busy_r     <= (state_nxt != IDLE);
      req_r      <= done || (req_r && !req_clear_i);
      if (done && conv_power_enable_i) begin
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
      end
    end
  end

  assign core_power_o      = conv_power_enable_i;
  assign core_sample_o     = (state_r == SAMPLE);
  assign conv_busy_flag_o  = busy_r;
  assign int_req_flag_o    = req_r;
  assign irq_o             = req_r && int_enable_i;
  assign result_high_reg_o = hi_r;
  assign result_low_reg_o  = lo_r;

  busy_on_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ce_i && go && state_r == IDLE |=> busy_r)
    else $error("busy not set after start");
  no_start_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ce_i && state_r == IDLE && !conv_power_enable_i |=> !busy_r)
    else $error("busy set while powered down");
  done_sets_req_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ce_i && done |=> req_r && !busy_r)
    else $error("completion did not set request and clear busy");
  irq_gate_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ce_i && done |=> irq_o == int_enable_i)
    else $error("interrupt not gated by enable");
  ext_off_int_a: assert property (@(posedge clock_i) disable iff (srst_i)
    src_int |-> ch_connect_o == 12'h000)
    else $error("external channel on with internal source");
  float_ch_a: assert property (@(posedge clock_i) disable iff (srst_i)
    src_ext && !ch_valid |-> ch_connect_o == 12'h000 && amux_sel_o == aic_pkg::AMUX_FLOAT)
    else $error("invalid channel not floating");
  gnd_src_a: assert property (@(posedge clock_i) disable iff (srst_i)
    input_source_select_i[3:2] == 2'b10 |-> amux_sel_o == aic_pkg::AMUX_GND)
    else $error("ground code not grounded");
  pin_override_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ((pin_pullup_o | pin_func_en_o) & pin_analog_sel_i) == 12'h000 &&
    (pin_dir_in_o & pin_analog_sel_i) == pin_analog_sel_i)
    else $error("analog pin keeps other functions");
  sample_len_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ce_i && state_r == SAMPLE && tick && tick_cnt_r == 4'(aic_pkg::SAMPLE_TICKS - 1)
    |=> state_r == CONVERT)
    else $error("sampling not four periods");
  hold_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
    !conv_power_enable_i |=> $stable(hi_r) && $stable(lo_r))
    else $error("result changed while disabled");

  conv_done_c: cover property (@(posedge clock_i) disable iff (srst_i) done);
  irq_c:       cover property (@(posedge clock_i) disable iff (srst_i) irq_o);
  abort_c:     cover property (@(posedge clock_i) disable iff (srst_i)
    busy_r && !conv_power_enable_i);
endmodule

// ===== testbench/aic_core_model.sv
// behavioural converter core: resolves a preset value, one decision per conversion tick
module aic_core_model (
  input  wire logic        clock_i,       // system clock
  input  wire logic        core_sample_i, // sampling phase from the block
  input  wire logic [2:0]  div_i,         // divide code in use
  input  wire logic [11:0] pattern_i,     // value the core resolves
  output logic             core_bit_o     // decision bit, msb first
);
  timeunit 1ns;
  timeprecision 1ps;

  // bits move 1 ns after the tick edge so the block never samples a changing line
  initial begin
    core_bit_o = 1'b0;
    forever begin
      @(negedge core_sample_i);
      for (int i = 11; i >= 0; i--) begin
        core_bit_o = pattern_i[i];
        repeat (1 << div_i) @(posedge clock_i);
        #1;
      end
      // no decision pending: show the opposite level so a late sample is caught
      core_bit_o = ~core_bit_o;
    end
  end
endmodule

// ===== testbench/aic_top_tb.sv
// self-checking bench for the converter input select and conversion control block
module aic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic        ce      = 1'b1;
  logic [3:0]  src = 4'h0, chan = 4'h0;
  logic [2:0]  div = 3'h0;
  logic        pwr = 1'b0, fmt = 1'b0, start = 1'b0, int_en = 1'b0, req_clr = 1'b0;
  logic [11:0] asel = 12'h000, pull = 12'h000, dir = 12'h000, func = 12'h000;
  logic [11:0] pattern = 12'h000;
  logic        core_bit, core_pwr, sample, busy, req, irq;
  logic [11:0] pull_o, dir_o, func_o, ch_o;
  logic [2:0]  amux;
  logic [1:0]  att;
  logic [7:0]  res_h, res_l;
  int          n_errors = 0;
  int          check_count = 0;
  int          n;
  bit          ext;

  always #12.5 clock_i = ~clock_i;

  aic_top i_aic_top (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce),
    .input_source_select_i(src), .external_channel_select_i(chan),
    .conv_clock_divide_i(div), .conv_power_enable_i(pwr), .result_format_select_i(fmt),
    .start_i(start), .int_enable_i(int_en), .req_clear_i(req_clr),
    .pin_analog_sel_i(asel), .pin_pullup_i(pull), .pin_dir_in_i(dir), .pin_func_en_i(func),
    .core_bit_i(core_bit), .pin_pullup_o(pull_o), .pin_dir_in_o(dir_o),
    .pin_func_en_o(func_o), .ch_connect_o(ch_o), .amux_sel_o(amux), .atten_o(att),
    .core_power_o(core_pwr), .core_sample_o(sample), .conv_busy_flag_o(busy),
    .int_req_flag_o(req), .irq_o(irq), .result_high_reg_o(res_h), .result_low_reg_o(res_l));

  aic_core_model i_aic_core_model (.clock_i(clock_i), .core_sample_i(sample), .div_i(div),
    .pattern_i(pattern), .core_bit_o(core_bit));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  // low-high-low on the start bit, one cycle high
  task automatic pulse_start;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(1);
  endtask

  // poll busy like software, whether or not the interrupt is enabled, bounded
  task automatic wait_done(output int cnt);
    cnt = 0;
    while (busy === 1'b1 && cnt < 5000) begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // longest path is about 4250 cycles of conversions
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    tick(16);
    srst_i = 1'b0;
    check("busy", 12'(busy), 12'h000);
    check("req", 12'(req), 12'h000);
    $display("test reset done");
    asel = 12'ha5a; pull = 12'hfff; dir = 12'h00f; func = 12'hfff;
    tick(1);
    check("func", func_o, 12'h5a5);
    check("pull", pull_o, 12'h5a5);
    check("dir", dir_o, 12'ha5f);
    $display("test pins done");
    for (int s = 0; s < 16; s++) begin
      src = 4'(s);
      chan = 4'h3;
      tick(1);
      ext = (s == 0 || s == 4 || s >= 12);
      if (ext) begin
        check("amux", 12'(amux), 12'(aic_pkg::AMUX_EXT));
        check("chan", ch_o, 12'h008);
      end else if (s >= 8) begin
        check("amux", 12'(amux), 12'(aic_pkg::AMUX_GND));
        check("chan", ch_o, 12'h000);
      end else begin
        check("amux", 12'(amux), s < 4 ? 12'(aic_pkg::AMUX_AVDD) : 12'(aic_pkg::AMUX_VVR));
        check("att", 12'(att), 12'((s & 3) - 1));
        check("chan", ch_o, 12'h000);
      end
    end
    src = 4'h0; chan = 4'hb;
    tick(1);
    check("chan", ch_o, 12'h800);
    chan = 4'hc;
    tick(1);
    check("chan", ch_o, 12'h000);
    check("amux", 12'(amux), 12'(aic_pkg::AMUX_FLOAT));
    $display("test routing done");
    pwr = 1'b1;
    tick(20);
    for (int d = 0; d < 8; d++) begin
      div = 3'(d);
      fmt = d[0]; int_en = d[1]; pattern = 12'ha5c ^ 12'(d * 12'h111); req_clr = 1'b1;
      tick(1);
      req_clr = 1'b0;
      pulse_start();
      check("busy", 12'(busy), 12'h001);
      check("sample", 12'(sample), 12'h001);
      wait_done(n);
      check("length", 12'(n), 12'(16 << d));
      check("req", 12'(req), 12'h001);
      check("irq", 12'(irq), 12'(d[1]));
      check("high", 12'(res_h), fmt ? 12'(pattern[11:8]) : 12'(pattern[11:4]));
      check("low", 12'(res_l), fmt ? 12'(pattern[7:0]) : {4'h0, pattern[3:0], 4'h0});
    end
    $display("test conversions done");
    div = 3'h0;
    pulse_start();
    tick(5);
    pulse_start();
    wait_done(n);
    check("length", 12'(n), 12'h009);
    req_clr = 1'b1;
    tick(3);
    req_clr = 1'b0;
    check("busy", 12'(busy), 12'h000);
    check("req", 12'(req), 12'h000);
    $display("test restart done");
    // enable low in sampling freezes the run: seven frozen edges stretch busy by seven
    pulse_start();
    ce = 1'b0;
    tick(7);
    check("sample", 12'(sample), 12'h001);
    check("busy", 12'(busy), 12'h001);
    ce = 1'b1;
    wait_done(n);
    check("length", 12'(n), 12'h010);
    check("low", 12'(res_l), 12'(pattern[7:0]));
    req_clr = 1'b1;
    tick(1);
    req_clr = 1'b0;
    $display("test enable done");
    pwr = 1'b0;
    tick(1);
    pulse_start();
    check("busy", 12'(busy), 12'h000);
    check("power", 12'(core_pwr), 12'h000);
    pwr = 1'b1;
    tick(20);
    pulse_start();
    tick(10);
    pwr = 1'b0;
    tick(2);
    check("busy", 12'(busy), 12'h000);
    check("req", 12'(req), 12'h000);
    check("low", 12'(res_l), 12'(pattern[7:0]));
    $display("test power done");
    tally_and_finish();
  end
endmodule
